// [rcic_defs.vh]
`ifndef RCIC_DEFS_VH
`define RCIC_DEFS_VH
// apb register byte offsets
`define RCIC_OFF_STAT     12'h000
`define RCIC_OFF_FLAG     12'h004
`define RCIC_OFF_MASK     12'h008
`define RCIC_OFF_CTRL     12'h00c
`define RCIC_OFF_VEC      12'h010
`define RCIC_OFF_P6REF    12'h014
// status field positions
`define RCIC_ST_PINWAKE   2
`define RCIC_ST_WDOG      1
`define RCIC_ST_DOZE      0
// flag and mask positions
`define RCIC_IRQ_TIMER    0
`define RCIC_IRQ_PCHG     1
`define RCIC_IRQ_EXT      2
`define RCIC_NSRC         3
// ctrl field positions
`define RCIC_CT_GIE       0
`define RCIC_CT_EXTPIN    1
`define RCIC_CT_P6ARM     2
// reset values
`define RCIC_FLAG_RST     3'h0
`define RCIC_MASK_RST     3'h0
`define RCIC_STAT_POR     3'h3
// vectors
`define RCIC_VEC_HW       12'h008
`define RCIC_VEC_SW       12'h001
`endif

// [rcic_fall_det.v]
`timescale 1ns/1ps
`include "rcic_defs.vh"
// falling-edge detector, one per input bit
module rcic_fall_det #(
   parameter W = 1
) (
   // clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // data
   input  wire [W-1:0] din,
   output wire [W-1:0] fall
);
   reg [W-1:0] prev_r;
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               prev_r[i] <= 1'b1;
            else
               prev_r[i] <= din[i];
         end
         assign fall[i] = prev_r[i] & ~din[i];
      end
   endgenerate
endmodule // rcic_fall_det

// [rcic_pchg_det.v]
`timescale 1ns/1ps
`include "rcic_defs.vh"
// port-6 change detector against a software-latched reference
module rcic_pchg_det #(
   parameter W = 8
) (
   // clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // port
   input  wire [W-1:0] port_in,
   input  wire [W-1:0] port_is_in,
   input  wire         bit0_is_ext,
   input  wire         ref_load,
   // result
   output wire         change,
   output wire [W-1:0] ref_val
);
   reg  [W-1:0] ref_r;
   wire [W-1:0] watch;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ref_r <= {W{1'b1}};
      else if (ref_load)
         ref_r <= port_in;
   end
   // outputs and the ext pin never count
   assign watch   = port_is_in & {{(W-1){1'b1}}, ~bit0_is_ext};
   assign change  = |((ref_r ^ port_in) & watch);
   assign ref_val = ref_r;
endmodule // rcic_pchg_det

// [rcic_ctrl.v]
`timescale 1ns/1ps
`include "rcic_defs.vh"
module rcic_ctrl #(
   parameter P6W = 8
) (
   // clock and power-on reset
   input  wire                  pclk,
   input  wire                  presetn,
   // apb slave
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [11:0]           paddr,
   input  wire [31:0]           pwdata,
   output wire                  pready,
   output reg  [31:0]           prdata,
   output wire                  pslverr,
   // reset and wake causes
   input  wire                  ext_reset_pulse,
   input  wire                  wdog_expire,
   input  wire                  wdog_clear_op,
   input  wire                  sleep_op,
   // core instruction events
   input  wire                  global_irq_on_op,
   input  wire                  global_irq_off_op,
   input  wire                  return_from_isr_op,
   input  wire                  soft_irq_op,
   input  wire                  vector_taken,
   // interrupt sources
   input  wire                  timer_overflow,
   input  wire                  port6_bit0_pin,
   input  wire [P6W-1:0]        port6_in,
   input  wire [P6W-1:0]        port6_is_input,
   // to the core
   output reg                   core_reset,
   output reg                   asleep,
   output wire                  wake,
   output wire [2:0]            irq_req,
   output wire                  irq_take,
   output reg  [11:0]           vector_addr,
   output reg                   vector_valid
);
   reg  [2:0]           stat_r;
   reg  [2:0]           stat_nxt;
   reg  [2:0]           irq_flag_reg;
   reg  [2:0]           irq_mask_reg;
   reg                  gie_r;
   reg                  ext_sel_r;
   reg                  p6_arm_r;
   reg                  sw_pend_r;
   wire                 wr;
   wire                 rd;
   wire [1:0]           fall2;
   wire                 port_change_flag_evt;
   wire                 pchg_raw;
   wire [P6W-1:0]       p6_ref;
   wire                 ref_load;
   wire [2:0]           evt;

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr      = psel & penable & pwrite;
   assign rd      = psel & penable & ~pwrite;

   // reading the port latches the change reference
   assign ref_load = rd & (paddr == `RCIC_OFF_P6REF);

   rcic_fall_det #(.W(2)) u_fall (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({port6_bit0_pin, timer_overflow}),
      .fall    (fall2)
   );

   rcic_pchg_det #(.W(P6W)) u_pchg (
      .pclk        (pclk),
      .presetn     (presetn),
      .port_in     (port6_in),
      .port_is_in  (port6_is_input),
      .bit0_is_ext (ext_sel_r),
      .ref_load    (ref_load),
      .change      (pchg_raw),
      .ref_val     (p6_ref)
   );

   // port change only raises its flag while enabled
   assign port_change_flag_evt = pchg_raw & irq_mask_reg[`RCIC_IRQ_PCHG];
   assign evt[`RCIC_IRQ_TIMER] = fall2[0];
   assign evt[`RCIC_IRQ_PCHG]  = port_change_flag_evt;
   assign evt[`RCIC_IRQ_EXT]   = fall2[1] & ext_sel_r;

   assign irq_req  = irq_flag_reg & irq_mask_reg;
   // wake from sleep on a port change whose mask bit is set
   assign wake     = asleep & (pchg_raw & irq_mask_reg[`RCIC_IRQ_PCHG]);
   assign irq_take = gie_r & (|irq_req) & ~asleep;

   // cause flags
   always @* begin
      stat_nxt = stat_r;
      if (wdog_expire) begin
         if (asleep)
            stat_nxt = 3'b000;
         else
            stat_nxt = {1'b0, 1'b0, stat_r[`RCIC_ST_DOZE]};
      end else if (ext_reset_pulse) begin
         if (asleep)
            stat_nxt = 3'b010;
         else
            stat_nxt = {1'b0, stat_r[1:0]};
      end else if (wake) begin
         stat_nxt = 3'b110;
      end else if (wdog_clear_op) begin
         stat_nxt = {stat_r[`RCIC_ST_PINWAKE], 2'b11};
      end else if (sleep_op) begin
         stat_nxt = {stat_r[`RCIC_ST_PINWAKE], 2'b10};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r     <= `RCIC_STAT_POR;
         core_reset <= 1'b1;
         asleep     <= 1'b0;
      end else begin
         stat_r     <= stat_nxt;
         core_reset <= wdog_expire | ext_reset_pulse;
         if (wdog_expire | ext_reset_pulse | wake)
            asleep <= 1'b0;
         else if (sleep_op)
            asleep <= 1'b1;
      end
   end

   // flags, mask, enables; hardware set beats software clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag_reg <= `RCIC_FLAG_RST;
         irq_mask_reg <= `RCIC_MASK_RST;
         gie_r        <= 1'b0;
         ext_sel_r    <= 1'b0;
         p6_arm_r     <= 1'b0;
      end else if (wdog_expire | ext_reset_pulse) begin
         irq_flag_reg <= `RCIC_FLAG_RST;
         irq_mask_reg <= `RCIC_MASK_RST;
         gie_r        <= 1'b0;
      end else begin
         if (wr && paddr == `RCIC_OFF_FLAG)
            irq_flag_reg <= (irq_flag_reg & pwdata[2:0]) | evt;
         else
            irq_flag_reg <= irq_flag_reg | evt;
         if (wr && paddr == `RCIC_OFF_MASK)
            irq_mask_reg <= pwdata[2:0];
         if (wr && paddr == `RCIC_OFF_CTRL) begin
            ext_sel_r <= pwdata[`RCIC_CT_EXTPIN];
            p6_arm_r  <= pwdata[`RCIC_CT_P6ARM];
         end
         if (vector_taken)
            gie_r <= 1'b0;
         else if (global_irq_on_op | return_from_isr_op)
            gie_r <= 1'b1;
         else if (global_irq_off_op)
            gie_r <= 1'b0;
      end
   end

   // vector selection; software request has its own address
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_pend_r    <= 1'b0;
         vector_addr  <= 12'h000;
         vector_valid <= 1'b0;
      end else begin
         vector_valid <= 1'b0;
         if (vector_taken)
            sw_pend_r <= 1'b0;
         else if (soft_irq_op)
            sw_pend_r <= 1'b1;
         if (soft_irq_op | sw_pend_r) begin
            vector_addr  <= `RCIC_VEC_SW;
            vector_valid <= ~vector_taken;
         end else if (irq_take | (wake & gie_r & irq_mask_reg[`RCIC_IRQ_PCHG])) begin
            vector_addr  <= `RCIC_VEC_HW;
            vector_valid <= ~vector_taken;
         end
      end
   end

   // read mux; unmapped reads zero
   always @* begin
      prdata = 32'h0000_0000;
      case (paddr)
         `RCIC_OFF_STAT:  prdata = {29'h0, stat_r};
         `RCIC_OFF_FLAG:  prdata = {29'h0, irq_flag_reg};
         `RCIC_OFF_MASK:  prdata = {29'h0, irq_mask_reg};
         `RCIC_OFF_CTRL:  prdata = {29'h0, p6_arm_r, ext_sel_r, gie_r};
         `RCIC_OFF_VEC:   prdata = {20'h0, vector_addr};
         `RCIC_OFF_P6REF: prdata = {{(32-P6W){1'b0}}, port6_in};
         default:         prdata = 32'h0000_0000;
      endcase
   end
endmodule // rcic_ctrl

// [rcic_checker.sv]
`timescale 1ns/1ps
`include "rcic_defs.vh"
module rcic_checker (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // events
   input wire        ext_reset_pulse,
   input wire        wdog_expire,
   input wire        sleep_op,
   input wire        soft_irq_op,
   input wire        vector_taken,
   // outputs
   input wire        core_reset,
   input wire        asleep,
   input wire        wake,
   input wire [2:0]  irq_req,
   input wire        irq_take,
   input wire [11:0] vector_addr,
   input wire        vector_valid
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ext_rst_a: assert property (ext_reset_pulse |=> core_reset)
      else $error("no reset after pulse");
   wdog_rst_a: assert property (wdog_expire |=> core_reset)
      else $error("no reset after watchdog");
   sleep_in_a: assert property (sleep_op && !ext_reset_pulse && !wdog_expire |=> asleep)
      else $error("sleep not entered");
   wake_out_a: assert property (wake |-> asleep ##1 !asleep)
      else $error("wake did not leave sleep");
   take_req_a: assert property (irq_take |-> irq_req != 3'h0 && !asleep)
      else $error("take without request");
   take_clr_a: assert property (vector_taken |=> !irq_take)
      else $error("enable kept after vector");
   hw_vec_a: assert property (
      $rose(irq_take) && !soft_irq_op |-> ##[1:2] vector_valid && vector_addr == `RCIC_VEC_HW)
      else $error("bad hardware vector");
   sw_vec_a: assert property (
      soft_irq_op |-> ##[1:2] vector_valid && vector_addr == `RCIC_VEC_SW)
      else $error("bad software vector");
   cover property (wake);
   cover property ($rose(irq_take));
   cover property (vector_taken && vector_addr == `RCIC_VEC_SW);
endmodule // rcic_checker
bind rcic_ctrl rcic_checker u_rcic_checker (.pclk(pclk), .presetn(presetn),
   .ext_reset_pulse(ext_reset_pulse), .wdog_expire(wdog_expire), .sleep_op(sleep_op),
   .soft_irq_op(soft_irq_op), .vector_taken(vector_taken), .core_reset(core_reset),
   .asleep(asleep), .wake(wake), .irq_req(irq_req), .irq_take(irq_take),
   .vector_addr(vector_addr), .vector_valid(vector_valid));

// [rcic_core_model.sv]
`timescale 1ns/1ps
module rcic_core_model (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // vector handshake
   input wire        vector_valid,
   input wire [11:0] vector_addr,
   input wire [3:0]  ack_delay,
   output reg        vector_taken,
   output reg [11:0] fetch_addr
);
   reg [3:0] wait_r;
   // a slow core holds the request pending for ack_delay cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_r <= 4'h0;
         vector_taken <= 1'b0;
         fetch_addr <= 12'h000;
      end else begin
         vector_taken <= 1'b0;
         if (vector_valid && !vector_taken) begin
            wait_r <= (wait_r == ack_delay) ? 4'h0 : wait_r + 4'h1;
            if (wait_r == ack_delay) begin
               vector_taken <= 1'b1;
               fetch_addr <= vector_addr;
            end
         end
      end
   end
endmodule // rcic_core_model

// [rcic_ctrl_tb.sv]
`timescale 1ns/1ps
`include "rcic_defs.vh"
module rcic_ctrl_tb;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   reg  [7:0]  ev = 8'h00;
   reg         tmr = 1'b1;
   reg         pin0 = 1'b1;
   reg  [7:0]  p6 = 8'hff;
   reg  [31:0] rd;
   integer     n_errors = 0;
   integer     num_checks = 0;
   integer     cyc = 0;
   wire        pready, pslverr, core_reset, asleep, wake, irq_take, vector_valid, vector_taken;
   wire [31:0] prdata;
   wire [2:0]  irq_req;
   wire [11:0] vector_addr, fetch_addr;
   rcic_ctrl u_rcic_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .ext_reset_pulse(ev[0]), .wdog_expire(ev[1]), .wdog_clear_op(ev[2]),
      .sleep_op(ev[3]), .global_irq_on_op(ev[4]), .global_irq_off_op(ev[5]),
      .return_from_isr_op(ev[6]), .soft_irq_op(ev[7]), .vector_taken(vector_taken),
      .timer_overflow(tmr), .port6_bit0_pin(pin0), .port6_in(p6), .port6_is_input(8'h7f),
      .core_reset(core_reset), .asleep(asleep), .wake(wake), .irq_req(irq_req),
      .irq_take(irq_take), .vector_addr(vector_addr), .vector_valid(vector_valid));
   rcic_core_model u_rcic_core_model (.pclk(pclk), .presetn(presetn),
      .vector_valid(vector_valid), .vector_addr(vector_addr), .ack_delay(4'h3),
      .vector_taken(vector_taken), .fetch_addr(fetch_addr));
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         complete_run;
      end
   end
   task complete_run;
      begin
         $display("checks %0d errors %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // released a cycle before the next setup, so no signal is set twice at one edge
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         rd = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task rdc(input [63:0] nm, input [11:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, rd, exp);
      end
   endtask
   task op(input [7:0] e);
      begin
         ev <= e;
         @(posedge pclk);
         ev <= 8'h00;
         repeat (2) @(posedge pclk);
      end
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc("stat", `RCIC_OFF_STAT, 32'h3);
      rdc("none", 12'h018, 32'h0);
      op(8'h08);
      rdc("stat", `RCIC_OFF_STAT, 32'h2);
      op(8'h02);
      rdc("stat", `RCIC_OFF_STAT, 32'h0);
      op(8'h04);
      rdc("stat", `RCIC_OFF_STAT, 32'h3);
      op(8'h02);
      rdc("stat", `RCIC_OFF_STAT, 32'h1);
      op(8'h08);
      op(8'h01);
      rdc("stat", `RCIC_OFF_STAT, 32'h2);
      apb(1'b1, `RCIC_OFF_CTRL, 32'h2);
      rdc("port", `RCIC_OFF_P6REF, 32'hff);
      apb(1'b1, `RCIC_OFF_MASK, 32'h2);
      op(8'h08);
      p6 <= 8'h7e;
      repeat (3) @(posedge pclk);
      chk("asleep", asleep, 1);
      p6 <= 8'h76;
      repeat (3) @(posedge pclk);
      chk("asleep", asleep, 0);
      chk("take", irq_take, 0);
      chk("req", irq_req, 2);
      rdc("stat", `RCIC_OFF_STAT, 32'h6);
      op(8'h01);
      rdc("stat", `RCIC_OFF_STAT, 32'h2);
      apb(1'b1, `RCIC_OFF_MASK, 32'h1);
      pin0 <= 1'b0;
      tmr <= 1'b0;
      @(posedge pclk);
      rdc("flag", `RCIC_OFF_FLAG, 32'h5);
      chk("req", irq_req, 1);
      op(8'h10);
      repeat (12) @(posedge pclk);
      chk("fetch", fetch_addr, 32'h8);
      rdc("ctrl", `RCIC_OFF_CTRL, 32'h2);
      apb(1'b1, `RCIC_OFF_FLAG, 32'h0);
      rdc("flag", `RCIC_OFF_FLAG, 32'h0);
      op(8'h40);
      rdc("ctrl", `RCIC_OFF_CTRL, 32'h3);
      op(8'h80);
      repeat (12) @(posedge pclk);
      chk("fetch", fetch_addr, 32'h1);
      op(8'h10);
      rdc("ctrl", `RCIC_OFF_CTRL, 32'h3);
      op(8'h20);
      rdc("ctrl", `RCIC_OFF_CTRL, 32'h2);
      // pin wake with the global enable on must vector
      rdc("port", `RCIC_OFF_P6REF, 32'h76);
      apb(1'b1, `RCIC_OFF_MASK, 32'h2);
      op(8'h10);
      op(8'h08);
      chk("asleep", asleep, 1);
      p6 <= 8'h66;
      repeat (12) @(posedge pclk);
      chk("asleep", asleep, 0);
      chk("fetch", fetch_addr, 32'h8);
      rdc("ctrl", `RCIC_OFF_CTRL, 32'h2);
      chk("rst", core_reset, 0);
      chk("slverr", pslverr, 0);
      complete_run;
   end
endmodule // rcic_ctrl_tb
